// file: rtl/wdt_cnt_if.sv
// link between the watchdog controller and its counter
`timescale 1ns/100ps
interface wdt_cnt_if;
    logic                      clear;
    logic                      tick;
    logic                      prescale_select;
    logic [3:0]                postscale_select;
    logic                      expire;
    logic                      window_open;
    logic [wdt_pkg::CNT_W-1:0] count;
    modport ctrl (output clear, tick, prescale_select, postscale_select,
                  input expire, window_open, count);
    modport cnt  (input clear, tick, prescale_select, postscale_select,
                  output expire, window_open, count);
endinterface

// file: rtl/wdt_counter.sv
// single count over the combined prescaler and postscaler period with expiry and window decode
`timescale 1ns/100ps
module wdt_counter (
    // clock and reset
    input wire logic CLK_SYS,
    input wire logic ARST_N,
    // controller side
    wdt_cnt_if.cnt   cif
);
    import wdt_pkg::*;
    typedef struct packed {
        logic [CNT_W-1:0] count;
        logic             expire;
        logic             window_open;
    } cnt_state_t;
    cnt_state_t s;
    cnt_state_t next_s;
    logic [CNT_W:0] span;
    logic [CNT_W:0] last;
    logic [CNT_W:0] open_at;
    logic [4:0]     e;

    // next count, expiry pulse and quarter window
    always_comb begin
        e = period_exp(cif.prescale_select, cif.postscale_select); // R14 R15
        span = (CNT_W+1)'(1) << e; // R1 R2 R3
        last = span - (CNT_W+1)'(1);
        open_at = span - (span >> 2); // R12
        next_s = s;
        next_s.expire = 1'b0;
        if (cif.clear) begin
            next_s.count = '0; // R4
        end else if (cif.tick) begin
            if ({1'b0, s.count} == last) begin
                next_s.count = '0;
                next_s.expire = 1'b1;
            end else begin
                next_s.count = s.count + CNT_W'(1);
            end
        end
        next_s.window_open = ({1'b0, next_s.count} >= open_at);
    end

    // state register
    always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign cif.count = s.count;
    assign cif.expire = s.expire;
    assign cif.window_open = s.window_open;

    default clocking dc @(posedge CLK_SYS); endclocking
    default disable iff (!ARST_N);
    a_clear_zeroes: assert property (cif.clear |=> s.count == '0 && !s.expire) // R4
        else $error("count not cleared");
    a_expire_wraps: assert property (s.expire |-> s.count == '0 && $past(cif.tick)) // R3
        else $error("expire without wrap");
    a_short_base: assert property (cif.tick && !cif.clear && !cif.prescale_select
        && cif.postscale_select == 4'h0 && s.count == 22'h00001f |=> s.expire) // R14
        else $error("short base period wrong");
    c_expire: cover property (s.expire);
endmodule

// file: rtl/wdt_pkg.sv
// constants, types and helpers shared by the windowed watchdog design
// Contract
// R1: the watchdog counts the low power rc clock through a prescaler dividing by 32 or by 128.
// R2: at the nominal 32 kHz the prescaler alone gives a base period of 1 ms or 4 ms.
// R3: a postscaler selected by config word bits 3..0 divides further, 16 ratios up to 1:32768.
// R4: counts clear on device reset, clock switch completion, power-save entry and exit, and kicks.
// R5: while enabled the watchdog keeps counting in sleep and idle.
// R6: a timeout in sleep or idle wakes the core instead of resetting it.
// R7: software clears the sleep and idle flags in bits 3 and 2 of reset_control_reg after a wake.
// R8: with fuse_always_on set the watchdog runs whatever soft_enable holds.
// R9: a timeout sets timeout_flag in bit 4 and it stays set until software clears it.
// R10: with fuse_always_on clear the watchdog runs only while soft_enable in bit 5 is set.
// R11: soft_enable is cleared by every device reset.
// R12: in window mode a kick before the final quarter of the period causes a watchdog reset.
// R13: a timeout in normal running causes a device reset.
// R14: prescale_select at 1 picks 1:128 and at 0 picks 1:32.
// R15: postscale_select n picks a ratio of two to the power n.
// R16: window_disable at 1 picks non-window mode and at 0 window mode.
// R17: enabling the watchdog also enables its low power rc clock.
package wdt_pkg;
    // register byte offsets
    localparam logic [7:0] OFS_RESET_CONTROL = 8'h00;
    localparam logic [7:0] OFS_IRQ_STATUS    = 8'h04;
    localparam logic [7:0] OFS_IRQ_MASK      = 8'h08;
    localparam logic [7:0] OFS_COUNT         = 8'h0c;
    localparam logic [7:0] OFS_CONFIG        = 8'h10;
    localparam int         ADDR_W            = 8;
    // reset_control_reg fields
    localparam int BIT_IDLE_FLAG    = 2;
    localparam int BIT_SLEEP_FLAG   = 3;
    localparam int BIT_TIMEOUT_FLAG = 4;
    localparam int BIT_SOFT_ENABLE  = 5;
    // watchdog_config_word fields
    localparam int CFG_W            = 8;
    localparam int CFG_POST_LSB     = 0;
    localparam int BIT_PRESCALE     = 4;
    localparam int BIT_WINDOW_DIS   = 6;
    localparam int BIT_ALWAYS_ON    = 7;
    // interrupt status bits
    localparam int IRQ_W            = 3;
    localparam int IRQ_TIMEOUT      = 0;
    localparam int IRQ_WAKE         = 1;
    localparam int IRQ_EARLY_KICK   = 2;
    // reset values
    localparam logic             RST_SOFT_ENABLE = 1'b0;
    localparam logic [IRQ_W-1:0] RST_IRQ_MASK    = 3'h0;
    // timing: nominal rc rate and base periods
    localparam int LOW_POWER_RC_CLOCK_KHZ      = 32;
    localparam int BASE_SHORT_MS = 1;
    localparam int BASE_LONG_MS  = 4;
    localparam int PRE_SHORT     = LOW_POWER_RC_CLOCK_KHZ * BASE_SHORT_MS;
    localparam int PRE_LONG      = LOW_POWER_RC_CLOCK_KHZ * BASE_LONG_MS;
    localparam logic [4:0] PRE_SHORT_LOG2 = 5'($clog2(PRE_SHORT));
    localparam logic [4:0] PRE_LONG_LOG2  = 5'($clog2(PRE_LONG));
    localparam int CNT_W         = 22;
    // power mode, gray along run -> sleep -> idle
    typedef enum logic [1:0] {
        MODE_RUN   = 2'b00,
        MODE_SLEEP = 2'b01,
        MODE_IDLE  = 2'b11
    } mode_t;
    // period exponent: log2 of prescale plus postscale setting
    function automatic logic [4:0] period_exp(input logic pre, input logic [3:0] post);
        period_exp = (pre ? PRE_LONG_LOG2 : PRE_SHORT_LOG2) + {1'b0, post};
    endfunction
endpackage

// file: rtl/wdt_top.sv
// windowed watchdog controller with axi4-lite registers
//
// Chosen here: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
module wdt_top (
    // clock and reset
    input  wire logic                         CLK_SYS,
    input  wire logic                         ARST_N,
    // low power rc clock and its enable
    input  wire logic                         LOW_POWER_RC_CLOCK_CLK,
    output logic                              LOW_POWER_RC_CLOCK_ENABLE,
    // configuration word
    input  wire logic [wdt_pkg::CFG_W-1:0]    WDT_CONFIG_WORD,
    // core events
    input  wire logic                         KICK,
    input  wire logic                         POWER_SAVE,
    input  wire logic                         POWER_SAVE_IDLE,
    input  wire logic                         WAKE_OTHER,
    input  wire logic                         CLOCK_SWITCH_DONE,
    output logic                              WDT_RESET,
    output logic                              WAKE,
    output logic                              IRQ,
    // axi4-lite write channels
    input  wire logic [wdt_pkg::ADDR_W-1:0]   AWADDR,
    input  wire logic                         AWVALID,
    output logic                              AWREADY,
    input  wire logic [31:0]                  WDATA,
    input  wire logic [3:0]                   WSTRB,
    input  wire logic                         WVALID,
    output logic                              WREADY,
    output logic [1:0]                        BRESP,
    output logic                              BVALID,
    input  wire logic                         BREADY,
    // axi4-lite read channels
    input  wire logic [wdt_pkg::ADDR_W-1:0]   ARADDR,
    input  wire logic                         ARVALID,
    output logic                              ARREADY,
    output logic [31:0]                       RDATA,
    output logic [1:0]                        RRESP,
    output logic                              RVALID,
    input  wire logic                         RREADY
);
    import wdt_pkg::*;

    typedef struct packed {
        logic              sync1;
        logic              sync2;
        logic              low_power_rc_clock_prev;
        logic              soft_enable;
        logic              timeout_flag;
        logic              sleep_flag;
        logic              idle_flag;
        mode_t             mode;
        logic [IRQ_W-1:0]  irq_status;
        logic [IRQ_W-1:0]  irq_mask;
        logic              wdt_reset;
        logic              wake;
        logic              irq;
        logic              low_power_rc_clock_en;
        logic              clear;
        logic              tick;
        logic              awready;
        logic              wready;
        logic              aw_held;
        logic              w_held;
        logic [ADDR_W-1:0] awaddr;
        logic [31:0]       wdata;
        logic [3:0]        wstrb;
        logic              bvalid;
        logic [1:0]        bresp;
        logic              arready;
        logic              rvalid;
        logic [31:0]       rdata;
        logic [1:0]        rresp;
    } top_state_t;

    top_state_t s;
    top_state_t next_s;
    wdt_cnt_if  cif ();

    logic en;
    logic run;
    logic kick_run;
    logic early;
    logic expire;
    logic wr_go;
    logic wr_reset_control_reg;
    logic rd_hit;

    // true when the offset names a mapped register
    function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
        is_mapped = (a == OFS_RESET_CONTROL) || (a == OFS_IRQ_STATUS) || (a == OFS_IRQ_MASK)
            || (a == OFS_COUNT) || (a == OFS_CONFIG);
    endfunction

    // counter instance
    wdt_counter u_counter (
        .CLK_SYS (CLK_SYS),
        .ARST_N  (ARST_N),
        .cif     (cif.cnt)
    );

    // configuration and counter controls, all from flip-flops or static config
    assign cif.clear = s.clear;
    assign cif.tick = s.tick;
    assign cif.prescale_select = WDT_CONFIG_WORD[BIT_PRESCALE];
    assign cif.postscale_select = WDT_CONFIG_WORD[CFG_POST_LSB +: 4];

    // enable and event decode
    always_comb begin
        en = WDT_CONFIG_WORD[BIT_ALWAYS_ON] | s.soft_enable; // R8 R10
        run = (s.mode == MODE_RUN);
        kick_run = KICK && run && en;
        early = kick_run && !WDT_CONFIG_WORD[BIT_WINDOW_DIS] && !cif.window_open; // R12 R16
        expire = cif.expire && en;
        wr_go = s.aw_held && s.w_held && !s.bvalid;
        wr_reset_control_reg = wr_go && s.wstrb[0] && (s.awaddr == OFS_RESET_CONTROL);
        rd_hit = ARVALID && s.arready;
    end

    // next state
    always_comb begin
        next_s = s;
        // synchroniser and rc edge tick
        next_s.sync1 = LOW_POWER_RC_CLOCK_CLK;
        next_s.sync2 = s.sync1;
        next_s.low_power_rc_clock_prev = s.sync2;
        next_s.tick = en && s.sync2 && !s.low_power_rc_clock_prev; // R1 R5
        next_s.low_power_rc_clock_en = en; // R17
        next_s.wdt_reset = 1'b0;
        next_s.wake = 1'b0;
        next_s.clear = !en || CLOCK_SWITCH_DONE; // R4

        // software register writes
        if (wr_go) begin
            if (s.wstrb[0]) begin
                case (s.awaddr)
                    OFS_RESET_CONTROL: begin
                        next_s.soft_enable = s.wdata[BIT_SOFT_ENABLE];
                        next_s.timeout_flag = s.timeout_flag & s.wdata[BIT_TIMEOUT_FLAG];
                        next_s.sleep_flag = s.sleep_flag & s.wdata[BIT_SLEEP_FLAG]; // R7
                        next_s.idle_flag = s.idle_flag & s.wdata[BIT_IDLE_FLAG]; // R7
                    end
                    OFS_IRQ_STATUS: next_s.irq_status = s.irq_status & ~s.wdata[IRQ_W-1:0];
                    OFS_IRQ_MASK:   next_s.irq_mask = s.wdata[IRQ_W-1:0];
                    default: ;
                endcase
            end
        end

        // power modes, timeouts and kicks; hardware sets win over clears
        case (s.mode)
            MODE_RUN: begin
                if (expire || early) begin
                    next_s.wdt_reset = 1'b1; // R13 R12
                    next_s.timeout_flag = 1'b1; // R9
                    next_s.clear = 1'b1;
                    if (expire) begin
                        next_s.irq_status[IRQ_TIMEOUT] = 1'b1;
                    end
                    if (early) begin
                        next_s.irq_status[IRQ_EARLY_KICK] = 1'b1;
                    end
                end else if (POWER_SAVE) begin
                    next_s.mode = POWER_SAVE_IDLE ? MODE_IDLE : MODE_SLEEP;
                    next_s.idle_flag = s.idle_flag | POWER_SAVE_IDLE;
                    next_s.sleep_flag = s.sleep_flag | !POWER_SAVE_IDLE;
                    next_s.clear = 1'b1; // R4
                end
                if (kick_run) begin
                    next_s.clear = 1'b1; // R4
                end
            end
            MODE_SLEEP, MODE_IDLE: begin
                if (expire) begin
                    next_s.wake = 1'b1; // R6 R5
                    next_s.timeout_flag = 1'b1; // R9
                    next_s.irq_status[IRQ_WAKE] = 1'b1;
                    next_s.mode = MODE_RUN;
                    next_s.clear = 1'b1; // R4
                end else if (WAKE_OTHER) begin
                    next_s.mode = MODE_RUN;
                    next_s.clear = 1'b1; // R4
                end
            end
            default: begin
                next_s.mode = MODE_RUN;
            end
        endcase
        next_s.irq = |(next_s.irq_status & next_s.irq_mask);

        // write address and data capture, either order
        if (AWVALID && s.awready) begin
            next_s.aw_held = 1'b1;
            next_s.awaddr = AWADDR;
        end
        if (WVALID && s.wready) begin
            next_s.w_held = 1'b1;
            next_s.wdata = WDATA;
            next_s.wstrb = WSTRB;
        end
        if (wr_go) begin
            next_s.aw_held = 1'b0;
            next_s.w_held = 1'b0;
            next_s.bvalid = 1'b1;
            next_s.bresp = is_mapped(s.awaddr) ? 2'h0 : 2'h2;
        end else if (s.bvalid && BREADY) begin
            next_s.bvalid = 1'b0;
        end
        next_s.awready = !next_s.aw_held && !next_s.bvalid;
        next_s.wready = !next_s.w_held && !next_s.bvalid;

        // read channel
        if (rd_hit) begin
            next_s.rvalid = 1'b1;
            next_s.rresp = is_mapped(ARADDR) ? 2'h0 : 2'h2;
            next_s.rdata = 32'h0;
            case (ARADDR)
                OFS_RESET_CONTROL: begin
                    next_s.rdata[BIT_SOFT_ENABLE] = s.soft_enable;
                    next_s.rdata[BIT_TIMEOUT_FLAG] = s.timeout_flag;
                    next_s.rdata[BIT_SLEEP_FLAG] = s.sleep_flag;
                    next_s.rdata[BIT_IDLE_FLAG] = s.idle_flag;
                end
                OFS_IRQ_STATUS: next_s.rdata[IRQ_W-1:0] = s.irq_status;
                OFS_IRQ_MASK:   next_s.rdata[IRQ_W-1:0] = s.irq_mask;
                OFS_COUNT:      next_s.rdata[CNT_W-1:0] = cif.count;
                OFS_CONFIG:     next_s.rdata = {22'h0, s.mode, WDT_CONFIG_WORD};
                default:        next_s.rdata = 32'h0;
            endcase
        end else if (s.rvalid && RREADY) begin
            next_s.rvalid = 1'b0;
        end
        next_s.arready = !next_s.rvalid;
    end

    // state register; device reset clears soft_enable and all counts
    always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) begin
            s <= '0;
            s.soft_enable <= RST_SOFT_ENABLE; // R11
            s.irq_mask <= RST_IRQ_MASK;
            s.mode <= MODE_RUN;
            s.clear <= 1'b1; // R4
        end else begin
            s <= next_s;
        end
    end

    // outputs straight from flip-flops
    assign LOW_POWER_RC_CLOCK_ENABLE = s.low_power_rc_clock_en;
    assign WDT_RESET = s.wdt_reset;
    assign WAKE = s.wake;
    assign IRQ = s.irq;
    assign AWREADY = s.awready;
    assign WREADY = s.wready;
    assign BVALID = s.bvalid;
    assign BRESP = s.bresp;
    assign ARREADY = s.arready;
    assign RVALID = s.rvalid;
    assign RDATA = s.rdata;
    assign RRESP = s.rresp;

    default clocking dc @(posedge CLK_SYS); endclocking
    default disable iff (!ARST_N);

    a_reset_on_expire: assert property (expire && run |=> WDT_RESET && !WAKE) // R13
        else $error("no reset on timeout");
    a_wake_on_expire: assert property (expire && !run |=> WAKE && !WDT_RESET ##1 !WAKE) // R6
        else $error("no wake on sleep timeout");
    a_early_kick_reset: assert property (early |=> WDT_RESET && s.irq_status[IRQ_EARLY_KICK]) // R12
        else $error("early kick not punished");
    a_late_kick_ok: assert property (kick_run && cif.window_open && !expire |=> !WDT_RESET) // R12
        else $error("kick in window punished");
    a_flag_sticky: assert property (s.timeout_flag && !wr_reset_control_reg |=> s.timeout_flag) // R9
        else $error("timeout flag lost");
    a_flag_set: assert property (expire |=> s.timeout_flag) // R9
        else $error("timeout flag not set");
    a_always_on_runs: assert property (WDT_CONFIG_WORD[BIT_ALWAYS_ON] |=> LOW_POWER_RC_CLOCK_ENABLE) // R8 R17
        else $error("always-on not running");
    a_soft_off_stops: assert property (!WDT_CONFIG_WORD[BIT_ALWAYS_ON] && !s.soft_enable
        |=> !LOW_POWER_RC_CLOCK_ENABLE && s.clear) // R10
        else $error("disabled watchdog running");
    a_kick_clears: assert property (kick_run |=> s.clear ##1 cif.count == '0) // R4
        else $error("kick did not clear count");
    a_sleep_counts: assert property (en && !run && s.sync2 && !s.low_power_rc_clock_prev |=> s.tick) // R5
        else $error("no counting in sleep");
    a_irq_level: assert property (|(s.irq_status & s.irq_mask) |-> IRQ)
        else $error("irq not raised");

    c_timeout_reset: cover property (expire && run);
    c_sleep_wake: cover property (POWER_SAVE && run ##[1:1000] WAKE);
    c_early_kick: cover property (early);
    c_good_kick: cover property (kick_run && cif.window_open);
endmodule

// file: verification/core_model.sv
// cpu core model: event pulses and the low power rc oscillator
`timescale 1ns/100ps
module core_model (
    // clock
    input  wire logic CLK_SYS,
    // core events
    output logic      KICK,
    output logic      POWER_SAVE,
    output logic      POWER_SAVE_IDLE,
    output logic      WAKE_OTHER,
    output logic      CLOCK_SWITCH_DONE,
    // rc oscillator and its enable
    input  wire logic LOW_POWER_RC_CLOCK_ENABLE,
    output logic      LOW_POWER_RC_CLOCK_CLK
);
    logic rc_run;
    // 160 ns rc clock, phase unrelated to the system clock; runs only while enabled
    // and not paused, so a watchdog that fails to enable its source never counts
    initial begin
        {KICK, POWER_SAVE, POWER_SAVE_IDLE, WAKE_OTHER, CLOCK_SWITCH_DONE} = 5'h00;
        LOW_POWER_RC_CLOCK_CLK = 1'b0;
        rc_run = 1'b1;
        #7;
        forever begin
            #80;
            if (rc_run && LOW_POWER_RC_CLOCK_ENABLE === 1'b1) LOW_POWER_RC_CLOCK_CLK = ~LOW_POWER_RC_CLOCK_CLK;
        end
    end
    // one cycle pulse: 0 kick, 1 sleep, 2 idle, 3 other wake, 4 clock switch
    task automatic fire(input int ev);
        @(posedge CLK_SYS);
        KICK <= (ev == 0);
        POWER_SAVE <= (ev == 1 || ev == 2);
        POWER_SAVE_IDLE <= (ev == 2);
        WAKE_OTHER <= (ev == 3);
        CLOCK_SWITCH_DONE <= (ev == 4);
        @(posedge CLK_SYS);
        {KICK, POWER_SAVE, WAKE_OTHER, CLOCK_SWITCH_DONE} <= 4'h0;
    endtask
endmodule

// file: verification/windowed_watchdog_timer_tb_top.sv
// self-checking bench for the windowed watchdog
`timescale 1ns/100ps
module windowed_watchdog_timer_tb_top;
    import wdt_pkg::*;
    logic        CLK_SYS, ARST_N, LOW_POWER_RC_CLOCK_CLK, LOW_POWER_RC_CLOCK_ENABLE, KICK, POWER_SAVE, POWER_SAVE_IDLE;
    logic        WAKE_OTHER, CLOCK_SWITCH_DONE, WDT_RESET, WAKE, IRQ, AWVALID, AWREADY;
    logic        WVALID, WREADY, BVALID, BREADY, ARVALID, ARREADY, RVALID, RREADY;
    logic [7:0]  WDT_CONFIG_WORD, AWADDR, ARADDR;
    logic [31:0] WDATA, RDATA, r;
    logic [3:0]  WSTRB;
    logic [1:0]  BRESP, RRESP;
    logic [33:0] rd_q[$], exp_r;
    logic [1:0]  ev_q[$];
    int          error_cnt, compares, rc_n, p;
    int          evs[6] = '{0, 2, 3, 1, 3, 4};

    wdt_top dut_u (.CLK_SYS, .ARST_N, .LOW_POWER_RC_CLOCK_CLK, .LOW_POWER_RC_CLOCK_ENABLE, .WDT_CONFIG_WORD, .KICK,
        .POWER_SAVE, .POWER_SAVE_IDLE, .WAKE_OTHER, .CLOCK_SWITCH_DONE, .WDT_RESET, .WAKE,
        .IRQ, .AWADDR, .AWVALID, .AWREADY, .WDATA, .WSTRB, .WVALID, .WREADY, .BRESP,
        .BVALID, .BREADY, .ARADDR, .ARVALID, .ARREADY, .RDATA, .RRESP, .RVALID, .RREADY);
    core_model core_u (.CLK_SYS, .KICK, .POWER_SAVE, .POWER_SAVE_IDLE, .WAKE_OTHER,
        .CLOCK_SWITCH_DONE, .LOW_POWER_RC_CLOCK_ENABLE, .LOW_POWER_RC_CLOCK_CLK);

    // 50 mhz system clock
    initial begin
        CLK_SYS = 1'b0;
        forever #10 CLK_SYS = ~CLK_SYS;
    end
    // rc edges seen since the last restart of the measurement
    always @(posedge LOW_POWER_RC_CLOCK_CLK) rc_n = rc_n + 1;

    task automatic chk(input logic [33:0] seen, input logic [33:0] exp, input string what);
        compares++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask
    task automatic end_sim;
        $display("counts: %0d compares, %0d mismatches", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic tmo;
        error_cnt++;
        $display("unexpected at %0t: wait ran out", $time);
        end_sim();
    endtask
    // axi write; the answer code is noted for the monitor
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] rsp);
        int   n;
        logic aw, w, b;
        rd_q.push_back({rsp, 32'h0});
        {aw, w, b} = 3'b000;
        AWADDR <= a;
        WDATA <= d;
        AWVALID <= 1'b1;
        WVALID <= 1'b1;
        BREADY <= 1'b1;
        for (n = 0; n < 40 && !b; n++) begin
            @(posedge CLK_SYS);
            if (!aw && AWREADY === 1'b1) begin
                aw = 1'b1;
                AWVALID <= 1'b0;
            end
            if (!w && WREADY === 1'b1) begin
                w = 1'b1;
                WVALID <= 1'b0;
            end
            if (aw && w && BVALID === 1'b1) begin
                b = 1'b1;
                BREADY <= 1'b0;
            end
        end
        if (!b) tmo();
        @(posedge CLK_SYS);
    endtask
    // axi read; the expected {resp, data} is noted for the monitor
    task automatic axi_rd(input logic [7:0] a, input logic [33:0] exp);
        int   n;
        logic got;
        rd_q.push_back(exp);
        got = 1'b0;
        ARADDR <= a;
        ARVALID <= 1'b1;
        RREADY <= 1'b1;
        for (n = 0; n < 40 && !got; n++) begin
            @(posedge CLK_SYS);
            if (ARREADY === 1'b1) ARVALID <= 1'b0;
            if (RVALID === 1'b1) begin
                got = 1'b1;
                RREADY <= 1'b0;
            end
        end
        if (!got) tmo();
        @(posedge CLK_SYS);
    endtask
    // note an expected {WAKE, WDT_RESET} pulse and wait for it
    task automatic wait_ev(input logic [1:0] ev, input int lim);
        int n;
        ev_q.push_back(ev);
        for (n = 0; n < lim && !(WAKE === 1'b1 || WDT_RESET === 1'b1); n++) @(posedge CLK_SYS);
        if (WAKE !== 1'b1 && WDT_RESET !== 1'b1) tmo();
    endtask
    task automatic wait_rc(input int k);
        int n;
        for (n = 0; n < k * 20 && rc_n < k; n++) @(posedge CLK_SYS);
        if (rc_n < k) tmo();
    endtask
    task automatic done(input string s);
        $display("test %s done at %0t", s, $time);
    endtask

    // monitor: every bus answer and every event pulse takes the oldest note
    always @(posedge CLK_SYS) begin
        if ((BVALID && BREADY) || (RVALID && RREADY)) begin
            exp_r = (rd_q.size() > 0) ? rd_q.pop_front() : 34'h3ffffffff;
            chk(BVALID ? {BRESP, 32'h0} : {RRESP, RDATA}, exp_r, "bus answer");
        end
        if (WAKE === 1'b1 || WDT_RESET === 1'b1) begin
            exp_r = (ev_q.size() > 0) ? {32'h0, ev_q.pop_front()} : 34'h3;
            chk({32'h0, WAKE, WDT_RESET}, exp_r, "event pulse");
        end
    end

    // main sequence
    initial begin
        {ARST_N, AWVALID, WVALID, BREADY, ARVALID, RREADY} = 6'h00;
        {AWADDR, ARADDR, WDATA} = 48'h0;
        WSTRB = 4'hf;
        WDT_CONFIG_WORD = 8'h40;
        {error_cnt, compares, rc_n} = 0;
        r = $urandom(32'h55bdbf8b);
        repeat (16) @(posedge CLK_SYS);
        ARST_N <= 1'b1;
        repeat (2) @(posedge CLK_SYS);
        // reset values, unmapped place, random mask
        foreach (evs[i]) if (i < 5) axi_rd(8'(4 * i), {27'h0, (i == 4), 6'h0});
        axi_rd(8'h14, {2'b10, 32'h0});
        r = $urandom;
        axi_wr(8'h14, r, 2'b10);
        axi_wr(OFS_IRQ_MASK, r, 2'b00);
        axi_rd(OFS_IRQ_MASK, {31'h0, r[2:0]});
        axi_wr(OFS_IRQ_MASK, 32'h0, 2'b00);
        done("registers");
        // timeout periods over both prescales and two postscales, always-on fuse
        for (int i = 0; i < 4; i++) begin
            WDT_CONFIG_WORD <= {3'b110, i[1], 3'b000, i[0]};
            p = 32 << (2 * i[1] + i[0]);
            core_u.fire(0);
            rc_n = 0;
            wait_ev(2'b01, p * 20 + 200);
            chk(34'(rc_n >= p - 1 && rc_n <= p + 1), 34'h1, "timeout period");
        end
        WDT_CONFIG_WORD <= 8'h40;
        repeat (3) @(posedge CLK_SYS);
        chk({33'h0, LOW_POWER_RC_CLOCK_ENABLE}, 34'h0, "rc enable off");
        axi_rd(OFS_RESET_CONTROL, 34'h10);
        axi_wr(OFS_RESET_CONTROL, 32'h0, 2'b00);
        axi_rd(OFS_RESET_CONTROL, 34'h0);
        done("timeouts");
        // window mode: early kick resets, a kick in the last quarter does not
        WDT_CONFIG_WORD <= 8'h81;
        rc_n = 0;
        wait_rc(10);
        core_u.fire(0);
        wait_ev(2'b01, 20);
        WDT_CONFIG_WORD <= 8'h41;
        repeat (4) @(posedge CLK_SYS);
        WDT_CONFIG_WORD <= 8'h81;
        rc_n = 0;
        wait_rc(52);
        core_u.fire(0);
        wait_rc(62);
        WDT_CONFIG_WORD <= 8'h40;
        done("window");
        // interrupt status, mask and level output
        axi_rd(OFS_IRQ_STATUS, 34'h5);
        chk({33'h0, IRQ}, 34'h0, "irq masked");
        axi_wr(OFS_IRQ_MASK, 32'h1, 2'b00);
        chk({33'h0, IRQ}, 34'h1, "irq raised");
        axi_wr(OFS_IRQ_STATUS, 32'h5, 2'b00);
        chk({33'h0, IRQ}, 34'h0, "irq cleared");
        axi_rd(OFS_IRQ_STATUS, 34'h0);
        done("interrupts");
        // software enable, sleep timeout wakes the core
        axi_wr(OFS_RESET_CONTROL, 32'h20, 2'b00);
        chk({33'h0, LOW_POWER_RC_CLOCK_ENABLE}, 34'h1, "rc enable on");
        core_u.fire(1);
        axi_rd(OFS_CONFIG, 34'h140);
        wait_ev(2'b10, 32 * 20 + 200);
        axi_rd(OFS_RESET_CONTROL, 34'h38);
        axi_wr(OFS_RESET_CONTROL, 32'h20, 2'b00);
        axi_rd(OFS_RESET_CONTROL, 34'h20);
        done("sleep wake");
        // kick, sleep and idle entry, other wake and clock switch each empty a frozen count
        foreach (evs[i]) begin
            core_u.rc_run = 1'b1;
            rc_n = 0;
            wait_rc(3);
            core_u.rc_run = 1'b0;
            repeat (6) @(posedge CLK_SYS);
            core_u.fire(evs[i]);
            repeat (3) @(posedge CLK_SYS);
            axi_rd(OFS_COUNT, 34'h0);
        end
        core_u.rc_run = 1'b1;
        done("count clears");
        // a second reset drops the software enable
        ARST_N <= 1'b0;
        repeat (16) @(posedge CLK_SYS);
        ARST_N <= 1'b1;
        repeat (2) @(posedge CLK_SYS);
        axi_rd(OFS_RESET_CONTROL, 34'h0);
        done("second reset");
        end_sim();
    end
endmodule
